// file: logic/gsu_frame_upload.v
`timescale 1ns/1ps
`include "gsu_defs.vh"
// Summary of operation
// - Serial line runs 4800 baud, 8 data bits, one stop, no parity.
// - A full frame is sent every second unprompted from power-on.
// - Warm-up state lasts about three minutes, then normal monitoring.
// - Frame is header 0xaa, status, concentration, checksum.
// - Checksum is low byte of header plus status plus concentration.
// - Status is 0x80 normal, 0x81 circuit fault, 0x82 warm-up.
// - Concentration reads zero throughout warm-up.
// - Concentration is 0 to 100 percent of lower explosive limit.
// - Above measurable range the concentration is sent as 0xff.
module gsu_frame_upload #(
  parameter FRAME_CYC = `GSU_FRAME_CYC,
  parameter WARM_CYC = `GSU_WARM_CYC,
  parameter BIT_CYC = `GSU_BIT_CYC
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] gas_level,
  input wire fault_in,
  output reg txd_r,
  output reg fault_output_reserved_r,
  output reg alarm_output_reserved_r
);
  localparam S_IDLE = 2'd0;
  localparam S_LOAD = 2'd1;
  localparam S_WAIT = 2'd2;
  // Last count of each timer, sized to the counters
  localparam [31:0] FRAME_LAST = FRAME_CYC - 1;
  localparam [31:0] WARM_LAST = WARM_CYC - 1;

  // Additive checksum over the first three bytes
  // Carries are dropped on purpose: the host sums the same way
  function [7:0] gsu_sum;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    reg [9:0] s;
    begin
      s = {2'b00, a} + {2'b00, b} + {2'b00, c};
      gsu_sum = s[7:0];
    end
  endfunction

  reg [1:0] st_r;
  reg [31:0] tick_r;
  reg [31:0] warm_r;
  reg warm_done_r;
  reg [1:0] idx_r;
  reg [7:0] stat_r;
  reg [7:0] conc_r;
  reg [7:0] lvl_s1_r;
  reg [7:0] lvl_s2_r;
  reg [7:0] lvl_s3_r;
  reg [7:0] lvl_hold_r;
  reg flt_s1_r;
  reg flt_s2_r;
  reg go_r;
  reg [7:0] byte_r;
  wire tx_line;
  wire tx_busy;
  reg [7:0] byte_nxt;

  // Sensor inputs come from outside this clock domain
  // Two-stage synchronisers for sensor inputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_s1_r <= 8'h00;
      lvl_s2_r <= 8'h00;
      flt_s1_r <= 1'b0;
      flt_s2_r <= 1'b0;
    end else begin
      lvl_s1_r <= gas_level;
      lvl_s2_r <= lvl_s1_r;
      flt_s1_r <= fault_in;
      flt_s2_r <= flt_s1_r;
    end
  end

  // Multi-bit level crossing: trust a word only after two equal
  // synchronised samples, so a snapshot never mixes bits of an old
  // and a new reading
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_s3_r <= 8'h00;
      lvl_hold_r <= 8'h00;
    end else begin
      lvl_s3_r <= lvl_s2_r;
      if (lvl_s2_r == lvl_s3_r) begin
        lvl_hold_r <= lvl_s2_r;
      end
    end
  end

  // Counts once from reset and then holds; any reset restarts warm-up
  // warm-up timer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warm_r <= 32'h00000000;
      warm_done_r <= 1'b0;
    end else if (!warm_done_r) begin
      if (warm_r == WARM_LAST) begin
        warm_done_r <= 1'b1;
      end else begin
        warm_r <= warm_r + 32'h00000001;
      end
    end
  end

  // Checksum comes from the held status and level bytes, so it always
  // matches the bytes already on the line
  // Byte selection for the current frame position
  always @* begin
    case (idx_r)
      2'd0: byte_nxt = `GSU_HDR;
      2'd1: byte_nxt = stat_r;
      2'd2: byte_nxt = conc_r;
      default: byte_nxt = gsu_sum(`GSU_HDR, stat_r, conc_r);
    endcase
  end

  // Frame sequencer: one-second tick, snapshot, send four bytes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_IDLE;
      tick_r <= 32'h00000000;
      idx_r <= 2'd0;
      stat_r <= `GSU_ST_WARM;
      conc_r <= 8'h00;
      go_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      go_r <= 1'b0;
      if (tick_r == FRAME_LAST) begin
        tick_r <= 32'h00000000;
      end else begin
        tick_r <= tick_r + 32'h00000001;
      end
      case (st_r)
        S_IDLE: begin
          // Snapshot inputs on the tick; a frame still in flight at a tick
          // loses that slot, so a frame must fit within one interval
          if (tick_r == 32'h00000000) begin
            idx_r <= 2'd0;
            st_r <= S_LOAD;
            // Warm-up wins over a fault, a fault wins over normal
            // status encoding
            if (!warm_done_r) begin
              stat_r <= `GSU_ST_WARM;
            end else if (flt_s2_r) begin
              stat_r <= `GSU_ST_FAULT;
            end else begin
              stat_r <= `GSU_ST_NORMAL;
            end
            if (!warm_done_r) begin
              conc_r <= 8'h00;
            end else if (lvl_hold_r > `GSU_CONC_MAX) begin
              conc_r <= `GSU_CONC_OVER;
            end else begin
              conc_r <= lvl_hold_r;
            end
          end
        end
        S_LOAD: begin
          if (!tx_busy) begin
            byte_r <= byte_nxt;
            go_r <= 1'b1;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          // go_r is still high in the first wait cycle, before the
          // transmitter has raised busy, so that cycle is skipped
          if (!go_r && !tx_busy) begin
            if (idx_r == 2'd3) begin
              st_r <= S_IDLE;
            end else begin
              idx_r <= idx_r + 2'd1;
              st_r <= S_LOAD;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Line returns high between bytes and between frames
  // 4800 baud 8N1 transmitter
  gsu_uart_tx #(
    .BIT_CYC(BIT_CYC)
  ) u_tx (
    .clk(clk),
    .rstn(rstn),
    .start(go_r),
    .data(byte_r),
    .txd_r(tx_line),
    .busy_r(tx_busy)
  );

  // One flop on the line keeps the pin free of glitches; the frame just
  // leaves one cycle later
  // Registered pins; reserved outputs held inactive
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txd_r <= 1'b1;
      fault_output_reserved_r <= 1'b0;
      alarm_output_reserved_r <= 1'b0;
    end else begin
      txd_r <= tx_line;
      fault_output_reserved_r <= 1'b0;
      alarm_output_reserved_r <= 1'b0;
    end
  end
endmodule // gsu_frame_upload

// file: logic/gsu_defs.vh
`ifndef GSU_DEFS_VH
`define GSU_DEFS_VH
// Clock rate in Hz
`define GSU_CLK_HZ 10000000
// Serial rate in baud
`define GSU_BAUD 4800
// Upload interval in ms and warm-up time in s
`define GSU_FRAME_MS 1000
`define GSU_WARM_S 180
// Cycles per bit, rounded down
`define GSU_BIT_CYC (`GSU_CLK_HZ / `GSU_BAUD)
// Cycles per frame interval and warm-up
`define GSU_FRAME_CYC (`GSU_CLK_HZ / 1000 * `GSU_FRAME_MS)
`define GSU_WARM_CYC (`GSU_CLK_HZ * `GSU_WARM_S)
// Frame bytes
`define GSU_HDR 8'haa
`define GSU_ST_NORMAL 8'h80
`define GSU_ST_FAULT 8'h81
`define GSU_ST_WARM 8'h82
`define GSU_CONC_MAX 8'h64
`define GSU_CONC_OVER 8'hff
`define GSU_NBYTES 4
`endif

// file: logic/gsu_uart_tx.v
`timescale 1ns/1ps
`include "gsu_defs.vh"
// 8N1 transmitter, one byte per start pulse
module gsu_uart_tx #(
  parameter BIT_CYC = `GSU_BIT_CYC
) (
  input wire clk,
  input wire rstn,
  input wire start,
  input wire [7:0] data,
  output reg txd_r,
  output reg busy_r
);
  reg [15:0] cnt_r;
  reg [3:0] bit_r;
  reg [8:0] sh_r;
  // Bit timing and shifting: start, 8 data LSB first, stop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txd_r <= 1'b1;
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 9'h1ff;
    end else if (!busy_r) begin
      if (start) begin
        busy_r <= 1'b1;
        txd_r <= 1'b0;
        sh_r <= {1'b1, data};
        cnt_r <= 16'h0000;
        bit_r <= 4'h0;
      end
    end else if (cnt_r == BIT_CYC[15:0] - 16'h0001) begin
      cnt_r <= 16'h0000;
      if (bit_r == 4'h9) begin
        busy_r <= 1'b0;
      end else begin
        txd_r <= sh_r[0];
        sh_r <= {1'b1, sh_r[8:1]};
        bit_r <= bit_r + 4'h1;
      end
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // gsu_uart_tx

// file: verif/gsu_frame_sva.sv
`timescale 1ns/1ps
// Watches line timing and the reserved pins of the uploader
module gsu_frame_sva #(
  parameter int FRAME_CYC = 2000,
  parameter int BIT_CYC = 20
) (
  input wire clk,
  input wire rstn,
  input wire txd_r,
  input wire fault_output_reserved_r,
  input wire alarm_output_reserved_r
);
  int hi_c, lo_c, pv_c;
  // High and low run lengths, and the high run before each fall
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_c <= 0;
      lo_c <= 0;
      pv_c <= 0;
    end else begin
      hi_c <= txd_r ? hi_c + 1 : 0;
      lo_c <= txd_r ? 0 : lo_c + 1;
      pv_c <= (!txd_r && hi_c != 0) ? hi_c : pv_c;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_bit; $changed(txd_r) |=> $stable(txd_r) [*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short"); // bit time
  property p_run; $rose(txd_r) |-> lo_c % BIT_CYC == 0; endproperty
  a_run: assert property (p_run) else $error("low run off grid"); // bit time
  property p_stop; lo_c <= 9 * BIT_CYC; endproperty
  a_stop: assert property (p_stop) else $error("stop bit missing"); // framing
  property p_first; $rose(rstn) |-> ##[1:8] $fell(txd_r); endproperty
  a_first: assert property (p_first) else $error("no frame after reset"); // unprompted
  property p_gap; $fell(txd_r) |-> hi_c < 10 * BIT_CYC || hi_c > FRAME_CYC - 50 * BIT_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("frame spacing"); // interval
  property p_hdr; $rose(txd_r) && pv_c > 10 * BIT_CYC |-> lo_c == 2 * BIT_CYC; endproperty
  a_hdr: assert property (p_hdr) else $error("header start"); // header
  property p_resf; !fault_output_reserved_r; endproperty
  a_resf: assert property (p_resf) else $error("fault pin active");
  property p_resa; !alarm_output_reserved_r; endproperty
  a_resa: assert property (p_resa) else $error("alarm pin active");
endmodule // gsu_frame_sva

bind gsu_frame_upload gsu_frame_sva #(.FRAME_CYC(FRAME_CYC), .BIT_CYC(BIT_CYC)) u_sva (
  .clk(clk), .rstn(rstn), .txd_r(txd_r), .fault_output_reserved_r(fault_output_reserved_r),
  .alarm_output_reserved_r(alarm_output_reserved_r));

// file: verif/gsu_host_rx.sv
`timescale 1ns/1ps
`include "gsu_defs.vh"
// Host receiver model
module gsu_host_rx #(
  parameter int BIT_CYC = 20
) (
  input wire logic clk,
  input wire logic rxd,
  output logic [7:0] st,
  output logic [7:0] conc,
  output logic ok,
  output int nfr
);
  logic [7:0] hd, sm;
  logic bad;
  task automatic rx_byte(output logic [7:0] v);
    @(negedge rxd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      v[i] = rxd;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (rxd !== 1'b1) bad = 1'b1;
  endtask
  initial begin
    nfr = 0;
    ok = 0;
    forever begin
      bad = 1'b0;
      rx_byte(hd);
      if (hd === `GSU_HDR) begin
        rx_byte(st);
        rx_byte(conc);
        rx_byte(sm);
        ok = !bad && (sm === 8'(hd + st + conc));
        nfr++;
      end
    end
  end
endmodule // gsu_host_rx

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "gsu_defs.vh"
module tb_top;
  logic clk = 0, rstn = 0, fault_in = 1, txd_r, ok, g_f;
  logic [7:0] gas_level = 8'h2a, st, conc, g, e_st;
  logic [7:0] lv [4] = '{8'h00, 8'h64, 8'h65, 8'hff};
  int nfr, num_errors = 0, samples_checked = 0, cyc = 0, last = 0, t;
  // Clock and cycle count
  initial forever #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  gsu_frame_upload #(.FRAME_CYC(2000), .WARM_CYC(5000), .BIT_CYC(20)) u_dut (.clk(clk),
    .rstn(rstn), .gas_level(gas_level), .fault_in(fault_in), .txd_r(txd_r),
    .fault_output_reserved_r(), .alarm_output_reserved_r());
  gsu_host_rx u_host (.clk(clk), .rxd(txd_r), .st(st), .conc(conc), .ok(ok), .nfr(nfr));
  // Frames 0-2 and the two after the mid-run reset fall in warm-up
  function automatic bit in_warm(int k);
    return k < 3 || k > 13;
  endfunction
  // Expected concentration byte
  function automatic logic [7:0] exp_conc(int k, logic [7:0] v);
    return in_warm(k) ? 8'h00 : v > `GSU_CONC_MAX ? `GSU_CONC_OVER : v;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Warm-up frames, level corners, random levels, faults, mid-run reset
  initial begin
    void'($urandom(32'h5c25));
    repeat (10) @(negedge clk);
    rstn = 1;
    for (int k = 0; k < 16; k++) begin
      // Reset between frames restarts warm-up with a fault pending
      if (k == 14) begin
        rstn = 0;
        repeat (10) @(negedge clk);
        rstn = 1;
      end
      g = gas_level;
      g_f = fault_in;
      for (t = 0; nfr == k && t < 3000; t++) @(negedge clk);
      if (t == 3000) begin
        num_errors++;
        break;
      end
      if (k > 0 && k != 14) chk("interval", 2000, cyc - last); // spacing
      last = cyc;
      e_st = in_warm(k) ? `GSU_ST_WARM : g_f ? `GSU_ST_FAULT : `GSU_ST_NORMAL;
      chk("status", e_st, st); // code
      if (in_warm(k) || !g_f) chk("level", exp_conc(k, g), conc); // level
      chk("sum", 1, ok); // frame
      gas_level = (k > 2 && k < 7) ? lv[k - 3] : 8'($urandom_range(120));
      fault_in = (k > 6 && k % 3 == 0) || k == 13;
    end
    print_verdict();
  end
endmodule // tb_top
